// *** logic/gpt_totalizer.sv ***
// Gated pulse totalizer: four 32-bit gated edge counters with APB registers
//
// Function
// - Four independent unsigned 32-bit count channels
// - Fast channels 10 MHz, normal 100 kHz
// - One count per selected rising/falling edge
// - Both gates: high gate high, low gate low
// - Only high gate driven: count while high
// - Only low gate driven: count while low
// - No gate detected: always count
// - Read-clear returns count, keeps pulses during read
// - Plain read leaves count unchanged
// - Count wraps from maximum to zero
// - Alarm when count reaches target, any channel
// - Scanned channels captured every scan
// - Unscanned channels started, stopped, read manually
//
// Added by the designer: register access over APB and the placing of the registers.
module gpt_totalizer
  import gpt_pkg::*;
(
  // Clock and reset
  input  wire  logic                        clock,
  input  wire  logic                        reset_n,
  // APB slave
  input  wire  logic                        psel,
  input  wire  logic                        penable,
  input  wire  logic                        pwrite,
  input  wire  logic [11:0]                 paddr,
  input  wire  logic [31:0]                 pwdata,
  output logic                              pready,
  output logic [31:0]                       prdata,
  output logic                              pslverr,
  // Pulse and gate pins
  input  wire  logic [gpt_pkg::CHAN_NUM-1:0] pulse_in,
  input  wire  gpt_pkg::gpt_gate_t          gate_pins,
  // Alarm and interrupt
  output logic [gpt_pkg::CHAN_NUM-1:0]      alarm_out,
  output logic                              irq
);
  timeunit 1ns;
  timeprecision 1ps;
  import gpt_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [31:0]          ctrl_q;                 // Control register
  logic [31:0]          scan_per_q;             // Scan period
  logic [1:0]           gate_det_q;             // Gate connected flags
  logic [STAT_W-1:0]    stat_q;                 // Sticky status
  logic [STAT_W-1:0]    mask_q;                 // Interrupt mask
  logic [STAT_W-1:0]    stat_clr;               // Write-one-clear bits this cycle
  logic [CHAN_NUM-1:0]  run_q;                  // Manual run flags
  logic [CNT_W-1:0]     cnt_q    [CHAN_NUM];    // Live counts
  logic [CNT_W-1:0]     snap_q   [CHAN_NUM];    // Scan snapshots
  logic [CNT_W-1:0]     target_q [CHAN_NUM];    // Alarm targets
  logic [CHAN_NUM-1:0]  pls_s1_q, pls_s2_q, pls_s3_q; // Pulse synchroniser
  logic [1:0]           gat_s1_q, gat_s2_q, gat_s3_q; // Gate synchroniser
  logic [CHAN_NUM-1:0]  pls_lvl_q;              // Agreed pulse level
  logic [1:0]           gat_lvl_q;              // Agreed gate level
  logic [31:0]          scan_tmr_q;             // Scan interval timer
  gpt_scan_state_t      scan_st_q;              // Scan sequencer
  gpt_chan_cfg_t        cfg [CHAN_NUM];         // Unpacked per channel cfg
  logic [CHAN_NUM-1:0]  edge_hit;               // Selected edge seen
  logic                 gate_ok;                // Gate allows counting
  logic [CHAN_NUM-1:0]  cnt_inc;                // Qualified count
  logic [CHAN_NUM-1:0]  rd_clr;                 // Read-clear this cycle
  logic [CHAN_NUM-1:0]  alarm_hit;              // Count reached target
  logic                 acc;                    // APB access phase
  logic                 wr;                     // Write taking effect
  logic                 rd;                     // Read taking effect
  logic [1:0]           widx;                   // Word index in array
  logic                 scan_done;              // Scan completed event
  logic [31:0]          rdata;                  // Read mux

  // Word select helper for arrays of four words at a base
  function automatic logic in_array(input logic [11:0] a, input logic [11:0] base);
    in_array = (a[11:4] == base[11:4]);
  endfunction : in_array

  ////////////////////////////////////////////////////////////////////////
  // Bus decode
  assign acc     = psel & penable;
  assign wr      = acc & pwrite;
  assign rd      = acc & ~pwrite;
  assign widx    = paddr[3:2];
  assign pready  = 1'b1;                       // Zero wait states
  assign pslverr = 1'b0;

  // Channel configuration fields
  always_comb begin
    for (int i = 0; i < CHAN_NUM; i++) begin
      cfg[i].falling  = ctrl_q[CTRL_EDGE_LSB + i];
      cfg[i].in_scan  = ctrl_q[CTRL_SCAN_LSB + i];
      cfg[i].rd_clear = ctrl_q[CTRL_RCLR_LSB + i];
      cfg[i].alarm_en = ctrl_q[CTRL_ALEN_LSB + i];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers: three stages, change taken once stages 2 and 3 agree
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pls_s1_q  <= '0;
      pls_s2_q  <= '0;
      pls_s3_q  <= '0;
      pls_lvl_q <= '0;
    end else begin
      pls_s1_q <= pulse_in;
      pls_s2_q <= pls_s1_q;
      pls_s3_q <= pls_s2_q;
      for (int i = 0; i < CHAN_NUM; i++) begin
        if (pls_s2_q[i] == pls_s3_q[i]) begin
          pls_lvl_q[i] <= pls_s3_q[i];
        end
      end
    end
  end

  // Gate synchroniser, idle gate levels are enabling
  // Reset levels enable the gate; gate detection is off after reset anyway
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      gat_s1_q  <= 2'h1;
      gat_s2_q  <= 2'h1;
      gat_s3_q  <= 2'h1;
      gat_lvl_q <= 2'h1;
    end else begin
      gat_s1_q <= {gate_pins.gate_lo_n, gate_pins.gate_hi};
      gat_s2_q <= gat_s1_q;
      gat_s3_q <= gat_s2_q;
      for (int i = 0; i < 2; i++) begin
        if (gat_s2_q[i] == gat_s3_q[i]) begin
          gat_lvl_q[i] <= gat_s3_q[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Edge detection on the agreed level; 40 MHz sampling resolves 10 MHz pulses
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      edge_hit <= '0;
    end else begin
      for (int i = 0; i < CHAN_NUM; i++) begin
        // Rising when level rises, falling when it falls
        edge_hit[i] <= (pls_s3_q[i] == pls_s2_q[i]) &&
                       (pls_s3_q[i] != pls_lvl_q[i]) &&
                       (pls_s3_q[i] ^ cfg[i].falling);
      end
    end
  end

  // Gate qualification per connected gate pins
  always_comb begin
    unique case (gate_det_q)
      2'b11:   gate_ok = gat_lvl_q[0] & ~gat_lvl_q[1];
      2'b01:   gate_ok = gat_lvl_q[0];
      2'b10:   gate_ok = ~gat_lvl_q[1];
      default: gate_ok = 1'b1;
    endcase
  end

  // Qualified increment after gating and run flag
  assign cnt_inc = edge_hit & {CHAN_NUM{gate_ok}} & run_q;

  ////////////////////////////////////////////////////////////////////////
  // Read-clear detection on count words
  always_comb begin
    for (int i = 0; i < CHAN_NUM; i++) begin
      rd_clr[i] = rd && in_array(paddr, OFF_COUNT) && (widx == i[1:0]) && cfg[i].rd_clear;
    end
  end

  // A read-clear and a pulse in one cycle leave a count of one, so no pulse
  // is lost across the clear; the plain increment rolls over past all ones
  // Counters: wrap, read-clear keeps a coincident pulse
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < CHAN_NUM; i++) begin
        cnt_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < CHAN_NUM; i++) begin
        if (rd_clr[i]) begin
          cnt_q[i] <= {{(CNT_W-1){1'b0}}, cnt_inc[i]};
        end else if (cnt_inc[i]) begin
          cnt_q[i] <= cnt_q[i] + 32'h0000_0001;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Manual run control, only for channels outside the scan list
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      run_q <= RUN_RST;
    end else begin
      for (int i = 0; i < CHAN_NUM; i++) begin
        if (cfg[i].in_scan) begin
          run_q[i] <= 1'b1;                    // Scanned channels always run
        end else if (wr && paddr == OFF_CMD && pwdata[CMD_STOP_LSB + i]) begin
          run_q[i] <= 1'b0;
        end else if (wr && paddr == OFF_CMD && pwdata[CMD_START_LSB + i]) begin
          run_q[i] <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Scan sequencer: timer expiry captures all scanned channels
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      scan_tmr_q <= '0;
      scan_st_q  <= GPT_SCAN_IDLE;
    end else begin
      unique case (scan_st_q)
        GPT_SCAN_IDLE: begin
          if (scan_tmr_q >= scan_per_q) begin
            scan_tmr_q <= '0;
            scan_st_q  <= GPT_SCAN_CAPTURE;
          end else begin
            scan_tmr_q <= scan_tmr_q + 32'h0000_0001;
          end
        end
        GPT_SCAN_CAPTURE: begin
          scan_st_q <= GPT_SCAN_IDLE;
        end
      endcase
    end
  end

  assign scan_done = (scan_st_q == GPT_SCAN_CAPTURE);

  // Snapshot capture on scan
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < CHAN_NUM; i++) begin
        snap_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < CHAN_NUM; i++) begin
        if (scan_done && cfg[i].in_scan) begin
          snap_q[i] <= cnt_q[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Alarm compare on every channel with its alarm enable set, scanned or not
  always_comb begin
    for (int i = 0; i < CHAN_NUM; i++) begin
      alarm_hit[i] = cfg[i].alarm_en && (cnt_q[i] == target_q[i]);
    end
  end

  // Alarm output, registered level
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      alarm_out <= '0;
    end else begin
      alarm_out <= alarm_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Writable configuration registers
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q     <= CTRL_RST;
      scan_per_q <= SCAN_PER_RST;
      gate_det_q <= '0;
      mask_q     <= '0;
    end else if (wr) begin
      if (paddr == OFF_CTRL)     ctrl_q     <= pwdata;
      if (paddr == OFF_SCAN_PER) scan_per_q <= pwdata;
      if (paddr == OFF_GATE_DET) gate_det_q <= pwdata[1:0];
      if (paddr == OFF_MASK)     mask_q     <= pwdata[STAT_W-1:0];
    end
  end

  // Alarm targets, one word per channel; all ones keeps them far from early counts
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < CHAN_NUM; i++) begin
        target_q[i] <= '1;
      end
    end else begin
      for (int i = 0; i < CHAN_NUM; i++) begin
        if (wr && in_array(paddr, OFF_TARGET) && (widx == i[1:0])) begin
          target_q[i] <= pwdata;
        end
      end
    end
  end

  // Bits that software writes as one to the status word
  assign stat_clr = (wr && paddr == OFF_STAT) ? pwdata[STAT_W-1:0] : '0;

  // Sticky status: set wins over write-one clear
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stat_q <= '0;
    end else begin
      stat_q <= (stat_q & ~stat_clr) | {scan_done, alarm_hit};
    end
  end

  // Level interrupt from unmasked status
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(stat_q & mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read mux; plain read leaves count untouched, unmapped reads zero
  always_comb begin
    rdata = '0;
    if (in_array(paddr, OFF_COUNT)) begin
      rdata = cnt_q[widx];
    end else if (in_array(paddr, OFF_SNAP)) begin
      rdata = snap_q[widx];
    end else if (in_array(paddr, OFF_TARGET)) begin
      rdata = target_q[widx];
    end else begin
      unique case (paddr)
        OFF_CTRL:     rdata = ctrl_q;
        OFF_STAT:     rdata = {27'h0, stat_q};
        OFF_MASK:     rdata = {27'h0, mask_q};
        OFF_SCAN_PER: rdata = scan_per_q;
        OFF_GATE_DET: rdata = {30'h0, gate_det_q};
        OFF_RUN:      rdata = {28'h0, run_q};
        default:      rdata = '0;
      endcase
    end
  end

  // Combinational read data during the access phase
  assign prdata = rd ? rdata : '0;

endmodule : gpt_totalizer

// *** logic/gpt_pkg.sv ***
// Package for the gated pulse totalizer: register map, fields, reset values, types
package gpt_pkg;
  timeunit 1ns;
  timeprecision 1ps;

  // Geometry
  localparam int          CHAN_NUM       = 4;          // Counter channels
  localparam int          CNT_W          = 32;         // Count width
  localparam int          SYNC_STAGES    = 3;          // Pin synchroniser depth

  // Register byte offsets
  localparam logic [11:0] OFF_CTRL       = 12'h000;    // Enables, edges, scan, clear modes
  localparam logic [11:0] OFF_CMD        = 12'h004;    // Manual start/stop
  localparam logic [11:0] OFF_STAT       = 12'h008;    // Sticky events, write one to clear
  localparam logic [11:0] OFF_MASK       = 12'h00c;    // Interrupt mask
  localparam logic [11:0] OFF_SCAN_PER   = 12'h010;    // Scan period in clocks
  localparam logic [11:0] OFF_GATE_DET   = 12'h014;    // Gate connected flags
  localparam logic [11:0] OFF_RUN        = 12'h018;    // Running flags (read only)
  localparam logic [11:0] OFF_COUNT      = 12'h020;    // Count read, 4 words
  localparam logic [11:0] OFF_SNAP       = 12'h030;    // Scan snapshot, 4 words
  localparam logic [11:0] OFF_TARGET     = 12'h040;    // Alarm target, 4 words

  // Control register field positions
  localparam int          CTRL_EDGE_LSB  = 0;          // 1 = falling edge counting
  localparam int          CTRL_SCAN_LSB  = 4;          // 1 = channel in scan list
  localparam int          CTRL_RCLR_LSB  = 8;          // 1 = read and clear
  localparam int          CTRL_ALEN_LSB  = 12;         // 1 = alarm compare enabled

  // Command register field positions
  localparam int          CMD_START_LSB  = 0;          // Start counting
  localparam int          CMD_STOP_LSB   = 4;          // Stop counting

  // Status register layout: alarm bits then scan-done bit
  localparam int          STAT_ALARM_LSB = 0;          // Per-channel alarm
  localparam int          STAT_SCAN_BIT  = 4;          // Scan completed
  localparam int          STAT_W         = 5;          // Status width

  // Reset values
  localparam logic [31:0] CTRL_RST       = 32'h0000_0000;
  localparam logic [31:0] SCAN_PER_RST   = 32'h0000_9c40; // One millisecond at 40 MHz
  localparam logic [3:0]  RUN_RST        = 4'hf;          // Counting on after reset

  // Per-channel configuration carried together
  typedef struct packed {
    logic falling;   // Edge select
    logic in_scan;   // Scan list member
    logic rd_clear;  // Read and clear mode
    logic alarm_en;  // Target compare enabled
  } gpt_chan_cfg_t;

  // Gate pins of one channel group
  typedef struct packed {
    logic gate_hi;   // Active-high gate level
    logic gate_lo_n; // Active-low gate level
  } gpt_gate_t;

  // Scan sequencer states
  typedef enum logic [0:0] {
    GPT_SCAN_IDLE,
    GPT_SCAN_CAPTURE
  } gpt_scan_state_t;

endpackage : gpt_pkg

// *** verification/gpt_pulse_src.sv ***
// Pulse sources and gate drivers facing the totalizer pins
module gpt_pulse_src
  import gpt_pkg::*;
(
  // Clock
  input  wire logic                    clock,
  // Driven pins
  output logic [gpt_pkg::CHAN_NUM-1:0] pulse_in,
  output gpt_pkg::gpt_gate_t           gate_pins
);
  timeunit 1ns;
  timeprecision 1ps;
  // Lines idle low, gates undriven levels
  initial begin
    pulse_in  = '0;
    gate_pins = '{gate_hi: 1'b0, gate_lo_n: 1'b1};
  end
  // Let clock edges pass
  task automatic hold(input int n);
    repeat (n) @(posedge clock);
  endtask : hold
  // Train of n pulses, w clocks high and low
  task automatic burst(input int ch, input int n, input int w);
    repeat (n) begin
      pulse_in[ch] <= 1'b1;
      hold(w);
      pulse_in[ch] <= 1'b0;
      hold(w);
    end
  endtask : burst
  // Park one line at a level
  task automatic level(input int ch, input logic v);
    pulse_in[ch] <= v;
    hold(1);
  endtask : level
  // Gate levels, settled before counting
  task automatic gate(input logic h, input logic l);
    gate_pins <= '{gate_hi: h, gate_lo_n: l};
    hold(6);
  endtask : gate
endmodule : gpt_pulse_src

// *** verification/gpt_totalizer_chk.sv ***
// Port checker for the gated pulse totalizer
module gpt_totalizer_chk
  import gpt_pkg::*;
(
  // Clock and reset
  input wire logic        clock,
  input wire logic        reset_n,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // Pins
  input wire logic [3:0]  pulse_in,
  input wire logic [3:0]  alarm_out,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] quiet_q; // Cycles without pin or bus activity
  logic [3:0] alen_q;  // Alarm enables last written
  logic [4:0] mask_q;  // Mask last written
  wire        wr = psel && penable && pwrite && pready;
  // Activity counter, saturating
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) quiet_q <= '0;
    else if (psel || $changed(pulse_in)) quiet_q <= '0;
    else if (quiet_q != 4'hf) quiet_q <= quiet_q + 4'h1;
  end
  // Shadow of alarm enables and mask
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      alen_q <= '0;
      mask_q <= '0;
    end else if (wr && paddr == OFF_CTRL) alen_q <= pwdata[CTRL_ALEN_LSB +: 4];
    else if (wr && paddr == OFF_MASK) mask_q <= pwdata[4:0];
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  chk_ready_high: assert property (pready) else $error("pready low");
  chk_no_slverr: assert property (!pslverr) else $error("slave error");
  chk_rdata_idle: assert property (!(psel && penable && !pwrite) |-> prdata == 32'h0)
    else $error("read data outside access");
  chk_unmapped_zero: assert property ((psel && penable && !pwrite && paddr >= 12'h050) |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  chk_alarm_quiet: assert property (quiet_q >= 4'h8 |-> $stable(alarm_out))
    else $error("alarm moved without cause");
  chk_alarm_enable: assert property ((alarm_out & ~alen_q & ~$past(alen_q)) == 4'h0)
    else $error("alarm on disabled channel");
  chk_irq_masked: assert property ((mask_q == 5'h0 && $past(mask_q) == 5'h0) |-> !irq)
    else $error("irq while masked");
  chk_reset_idle: assert property ($rose(reset_n) |-> alarm_out == 4'h0 && !irq)
    else $error("outputs busy after reset");
endmodule : gpt_totalizer_chk

bind gpt_totalizer gpt_totalizer_chk u_chk (.clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .pulse_in(pulse_in), .alarm_out(alarm_out), .irq(irq));

// *** verification/test_gated_pulse_totalizer.sv ***
// Self-checking bench for the gated pulse totalizer
module test_gated_pulse_totalizer;
  timeunit 1ns;
  timeprecision 1ps;
  import gpt_pkg::*;
  logic        clock = 1'b0;   // Bench clock
  logic        reset_n;        // Active-low reset
  logic        psel;           // APB request
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic        pready, pslverr, irq;
  logic [31:0] prdata, r, sum;
  logic [3:0]  pulse_in, alarm_out;
  gpt_gate_t   gate_pins;
  logic [31:0] exp_q[$];       // Expected read data
  int          n_mismatch = 0;
  int          total_checks = 0;
  int          nn[4];
  // Gate table: detect, high, low_n, counts
  logic [4:0]  gtab[8] = '{5'b11101, 5'b11110, 5'b11000, 5'b01111, 5'b01010, 5'b10001, 5'b10010, 5'b00011};
  always #12.5 clock = ~clock;
  gpt_totalizer u_dut (.clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .pulse_in(pulse_in), .gate_pins(gate_pins), .alarm_out(alarm_out), .irq(irq));
  gpt_pulse_src u_src (.clock(clock), .pulse_in(pulse_in), .gate_pins(gate_pins));
  ////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out
  // Compare one value
  task automatic cmp(input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: expected %h got %h", $time, e, g);
    end
  endtask : cmp
  // One APB transfer, entered just after an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 20);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
    if (k >= 20) begin
      n_mismatch++;
      close_out();
    end
  endtask : apb
  // Read with expectation noted
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd
  // Read results checked against the oldest note
  always @(posedge clock) begin
    if (psel && penable && !pwrite && pready === 1'b1 && exp_q.size() > 0) cmp(exp_q.pop_front(), prdata);
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    reset_n <= 1'b0;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwrite  <= 1'b0;
    paddr   <= '0;
    pwdata  <= '0;
    void'($urandom(32'hb430));
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    // Reset values, unmapped hole
    apb(1'b1, 12'h100, 32'hffff_ffff);
    rd(12'h100, 32'h0);
    rd(OFF_CTRL, CTRL_RST);
    rd(OFF_RUN, {28'h0, RUN_RST});
    rd(OFF_SCAN_PER, SCAN_PER_RST);
    for (int c = 0; c < 4; c++) begin
      rd(OFF_COUNT + 12'(4 * c), 32'h0);
      rd(OFF_TARGET + 12'(4 * c), 32'hffff_ffff);
    end
    apb(1'b1, OFF_SCAN_PER, 32'hffff_ffff);
    // Odd channels count falling edges; line parked high then low
    apb(1'b1, OFF_CTRL, 32'h0000_000a);
    for (int c = 0; c < 4; c++) begin
      nn[c] = 1 + $urandom % 6;
      u_src.burst(c, nn[c], c < 2 ? 2 : 200);
      u_src.level(c, 1'b1);
      u_src.hold(8);
      rd(OFF_COUNT + 12'(4 * c), 32'(nn[c] + (c % 2 == 0 ? 1 : 0)));
      u_src.level(c, 1'b0);
      u_src.hold(8);
      rd(OFF_COUNT + 12'(4 * c), 32'(nn[c] + 1));
    end
    // Read and clear mode on all channels
    apb(1'b1, OFF_CTRL, 32'h0000_0f00);
    for (int c = 0; c < 4; c++) begin
      rd(OFF_COUNT + 12'(4 * c), 32'(nn[c] + 1));
      rd(OFF_COUNT + 12'(4 * c), 32'h0);
    end
    // Clears during a pulse train lose nothing
    sum = '0;
    fork
      u_src.burst(0, 40, 2);
      repeat (12) begin
        apb(1'b0, OFF_COUNT, 32'h0);
        sum += r;
        u_src.hold($urandom % 12);
      end
    join
    u_src.hold(8);
    apb(1'b0, OFF_COUNT, 32'h0);
    cmp(32'd40, sum + r);
    // Gate combinations
    foreach (gtab[i]) begin
      apb(1'b1, OFF_GATE_DET, {30'h0, gtab[i][4:3]});
      u_src.gate(gtab[i][2], gtab[i][1]);
      u_src.burst(0, 3, 2);
      u_src.hold(8);
      rd(OFF_COUNT, gtab[i][0] ? 32'h3 : 32'h0);
    end
    apb(1'b1, OFF_GATE_DET, 32'h0);
    // Alarm on channel 1 at target five
    apb(1'b1, OFF_TARGET + 12'h4, 32'h5);
    apb(1'b1, OFF_MASK, 32'h2);
    apb(1'b1, OFF_CTRL, 32'h0000_2d00);
    u_src.burst(1, 5, 2);
    u_src.hold(8);
    cmp(32'h2, {28'h0, alarm_out});
    cmp(32'h1, {31'h0, irq});
    rd(OFF_STAT, 32'h2);
    apb(1'b1, OFF_MASK, 32'h0);
    u_src.burst(1, 1, 2);
    u_src.hold(8);
    cmp(32'h0, {27'h0, alarm_out, irq});
    apb(1'b1, OFF_STAT, 32'h1f);
    rd(OFF_STAT, 32'h0);
    // Manual stop and start of channel 0
    apb(1'b1, OFF_CMD, 32'h10);
    rd(OFF_RUN, 32'he);
    u_src.burst(0, 4, 2);
    u_src.hold(8);
    rd(OFF_COUNT, 32'h0);
    apb(1'b1, OFF_CMD, 32'h1);
    u_src.burst(0, 4, 2);
    u_src.hold(8);
    rd(OFF_COUNT, 32'h4);
    // Scanned channel ignores stop and is captured
    apb(1'b1, OFF_CTRL, 32'h0000_0d20);
    apb(1'b1, OFF_CMD, 32'h20);
    rd(OFF_RUN, 32'hf);
    apb(1'b1, OFF_SCAN_PER, 32'h4);
    u_src.hold(20);
    rd(OFF_SNAP + 12'h4, 32'h6);
    rd(OFF_STAT, 32'h10);
    close_out();
  end
endmodule : test_gated_pulse_totalizer
